/* uimsc_defs.svh */
// register offsets, field positions and reset values for the interrupt mask block
`ifndef UIMSC_DEFS_SVH
`define UIMSC_DEFS_SVH
`define UIMSC_MASK_OFFSET 3'h1
`define UIMSC_MASK_RESET 8'h00
`define UIMSC_BIT_CTS_DSR 7
`define UIMSC_BIT_RTS_DTR 6
`define UIMSC_BIT_XOFF 5
`define UIMSC_BIT_SLEEP 4
`define UIMSC_BIT_MODEM 3
`define UIMSC_BIT_LINE 2
`define UIMSC_BIT_TX_READY 1
`define UIMSC_RDATA_RESET 8'h00
`endif

/* uimsc_host.sv */
// host model driving the mask register port
`timescale 1ns/10ps
`default_nettype none
module uimsc_host (
   input wire logic clock,
   output var logic [2:0] reg_addr,
   output var logic reg_wr,
   output var logic reg_rd,
   output var logic [7:0] reg_wdata,
   output var logic divisor_latch_select,
   output var logic enhanced_function_gate
);
   // bus idle and gate closed until software opens it
   initial begin
      reg_addr = 3'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      divisor_latch_select = 1'b0;
      enhanced_function_gate = 1'b0;
   end
   // gate and latch select set ahead of the access they qualify
   task automatic set_ctl(input logic d, input logic g);
      divisor_latch_select <= d;
      enhanced_function_gate <= g;
   endtask
   // one access, strobe held up to the taking edge only
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* uimsc_pkg.sv */
// types shared by the interrupt mask and sleep control block
package uimsc_pkg;
   // pending sources, ordered like the mask bits they pair with
   typedef struct packed {
      logic cts_dsr;
      logic rts_dtr;
      logic xoff_special;
      logic modem_status;
      logic line_status;
      logic tx_ready;
   } uimsc_src_t;
   // conditions the sleep controller watches
   typedef struct packed {
      logic irq_pending;
      logic rx_in;
      logic tx_fifo_empty;
      logic rx_fifo_empty;
      logic tx_write;
   } uimsc_idle_t;
   typedef enum logic [1:0] {
      UIMSC_AWAKE = 2'b01,
      UIMSC_ASLEEP = 2'b10
   } uimsc_state_t;
endpackage

/* uimsc_sleep_ctrl.sv */
// sleep entry and wake control for one channel
`timescale 1ns/10ps
`default_nettype none
module uimsc_sleep_ctrl
   import uimsc_pkg::*;
#(
   parameter int MODEM_W = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sleep_en,
   input wire uimsc_idle_t idle,
   input wire logic [MODEM_W-1:0] modem_in,
   output logic sleeping,
   output logic osc_run
);
   if (MODEM_W < 1) begin : g_bad_width
      $error("modem width must be at least one");
   end

   uimsc_state_t state_reg;
   uimsc_state_t state_next;
   logic [MODEM_W-1:0] modem_prev_reg;
   logic modem_toggle;
   logic can_sleep;
   logic wake;

   // last modem sample, to spot toggles
   always_ff @(posedge clock or posedge rst) begin
      if (rst) modem_prev_reg <= '0;
      else modem_prev_reg <= modem_in;
   end

   assign modem_toggle = |(modem_in ^ modem_prev_reg);
   // every idle condition must hold at once
   assign can_sleep = sleep_en && !idle.irq_pending && !modem_toggle && idle.rx_in &&
      idle.tx_fifo_empty && idle.rx_fifo_empty && !idle.tx_write;
   // a start bit, modem activity or a transmit write ends sleep
   assign wake = modem_toggle || !idle.rx_in || idle.tx_write || !sleep_en;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         UIMSC_AWAKE: begin
            if (can_sleep) state_next = UIMSC_ASLEEP;
         end
         UIMSC_ASLEEP: begin
            if (wake) state_next = UIMSC_AWAKE;
         end
         default: state_next = UIMSC_AWAKE;
      endcase
   end

   // state plus registered outputs; oscillator stops only while asleep
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= UIMSC_AWAKE;
         sleeping <= 1'b0;
         osc_run <= 1'b1;
      end else begin
         state_reg <= state_next;
         sleeping <= (state_next == UIMSC_ASLEEP);
         osc_run <= (state_next != UIMSC_ASLEEP);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_enter_sleep;
      !sleeping && sleep_en && !idle.irq_pending && $stable(modem_in) && idle.rx_in &&
         idle.tx_fifo_empty && idle.rx_fifo_empty && !idle.tx_write |=> sleeping;
   endproperty
   a_enter_sleep: assert property (p_enter_sleep) else $error("idle channel did not sleep");

   property p_busy_stays_awake;
      !sleeping && (idle.irq_pending || !idle.rx_in || !idle.tx_fifo_empty) |=> !sleeping;
   endproperty
   a_busy_stays_awake: assert property (p_busy_stays_awake) else $error("busy channel slept");

   property p_wake;
      sleeping && (!idle.rx_in || idle.tx_write || !$stable(modem_in)) |=> !sleeping && osc_run;
   endproperty
   a_wake: assert property (p_wake) else $error("wake event ignored");

   property p_osc_stopped;
      sleeping |-> !osc_run;
   endproperty
   a_osc_stopped: assert property (p_osc_stopped) else $error("oscillator runs in sleep");

   property p_needs_enable;
      !sleep_en |=> !sleeping;
   endproperty
   a_needs_enable: assert property (p_needs_enable) else $error("slept without enable");

   c_sleep_wake: cover property (sleeping ##[1:20] !sleeping);
   c_tx_wake: cover property (sleeping && idle.tx_write);
endmodule
`default_nettype wire

/* uimsc_top.sv */
// per-channel interrupt mask register with sleep control
`timescale 1ns/10ps
`default_nettype none
`include "uimsc_defs.svh"
module uimsc_top
   import uimsc_pkg::*;
#(
   parameter int MODEM_W = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [2:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic divisor_latch_select,
   input wire logic enhanced_function_gate,
   input wire uimsc_src_t src_status,
   input wire logic [MODEM_W-1:0] modem_in,
   input wire logic rx_in,
   input wire logic tx_fifo_empty,
   input wire logic rx_fifo_empty,
   input wire logic tx_write,
   output logic [7:0] reg_rdata,
   output logic [7:0] uart_interrupt_mask,
   output uimsc_src_t pending_status,
   output logic irq,
   output logic sleeping,
   output logic osc_run
);
   if (MODEM_W < 1) begin : g_bad_width
      $error("modem width must be at least one");
   end

   logic [7:0] mask_reg;
   logic mask_hit;
   uimsc_src_t enable_vec;
   logic irq_next;
   logic sleep_en;
   uimsc_idle_t idle;

   // mask bits arranged like the source struct
   function automatic uimsc_src_t mask_to_src(input logic [7:0] m);
      mask_to_src = '{cts_dsr: m[`UIMSC_BIT_CTS_DSR], rts_dtr: m[`UIMSC_BIT_RTS_DTR],
                      xoff_special: m[`UIMSC_BIT_XOFF], modem_status: m[`UIMSC_BIT_MODEM],
                      line_status: m[`UIMSC_BIT_LINE], tx_ready: m[`UIMSC_BIT_TX_READY]};
   endfunction

   // register only visible with the divisor latch deselected
   assign mask_hit = (reg_addr == `UIMSC_MASK_OFFSET) && !divisor_latch_select;

   // upper half is locked unless the enhanced gate is open
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask_reg <= `UIMSC_MASK_RESET;
      end else if (reg_wr && mask_hit) begin
         mask_reg[3:0] <= reg_wdata[3:0];
         if (enhanced_function_gate) mask_reg[7:4] <= reg_wdata[7:4];
      end
   end

   // read data registered; other offsets belong to other blocks and read zero here
   always_ff @(posedge clock or posedge rst) begin
      if (rst) reg_rdata <= `UIMSC_RDATA_RESET;
      else if (reg_rd && mask_hit) reg_rdata <= mask_reg;
      else reg_rdata <= 8'h00;
   end

   // each source gated by its own enable; masked ones cannot hide others
   assign enable_vec = mask_to_src(mask_reg);
   assign irq_next = |(src_status & enable_vec);

   // raw status stays observable whatever the mask says
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
         pending_status <= '0;
         uart_interrupt_mask <= `UIMSC_MASK_RESET;
      end else begin
         irq <= irq_next;
         pending_status <= src_status;
         uart_interrupt_mask <= mask_reg;
      end
   end

   // sleep needs both its enable bit and the gate
   assign sleep_en = mask_reg[`UIMSC_BIT_SLEEP] && enhanced_function_gate;
   assign idle = '{irq_pending: irq_next, rx_in: rx_in, tx_fifo_empty: tx_fifo_empty,
                   rx_fifo_empty: rx_fifo_empty, tx_write: tx_write};

   uimsc_sleep_ctrl #(.MODEM_W(MODEM_W)) u_sleep (
      .clock(clock),
      .rst(rst),
      .sleep_en(sleep_en),
      .idle(idle),
      .modem_in(modem_in),
      .sleeping(sleeping),
      .osc_run(osc_run)
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_cts_irq;
      src_status.cts_dsr && mask_reg[7] |=> irq;
   endproperty
   a_cts_irq: assert property (p_cts_irq) else $error("cts/dsr interrupt lost");

   property p_rts_irq;
      src_status.rts_dtr && mask_reg[6] |=> irq;
   endproperty
   a_rts_irq: assert property (p_rts_irq) else $error("rts/dtr interrupt lost");

   property p_xoff_irq;
      src_status.xoff_special && mask_reg[5] |=> irq;
   endproperty
   a_xoff_irq: assert property (p_xoff_irq) else $error("xoff interrupt lost");

   property p_modem_irq;
      src_status.modem_status && mask_reg[3] |=> irq;
   endproperty
   a_modem_irq: assert property (p_modem_irq) else $error("modem interrupt lost");

   property p_line_irq;
      src_status.line_status && mask_reg[2] |=> irq;
   endproperty
   a_line_irq: assert property (p_line_irq) else $error("line status interrupt lost");

   property p_tx_irq;
      src_status.tx_ready && mask_reg[1] |=> irq;
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("tx ready interrupt lost");

   property p_masked_quiet;
      !(|(src_status & mask_to_src(mask_reg))) |=> !irq && pending_status == $past(src_status);
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("masked source interrupted");

   property p_gate_lock;
      reg_wr && !enhanced_function_gate |=> mask_reg[7:4] == $past(mask_reg[7:4]);
   endproperty
   a_gate_lock: assert property (p_gate_lock) else $error("upper enables changed while locked");

   property p_low_write;
      reg_wr && mask_hit |=> mask_reg[3:0] == $past(reg_wdata[3:0]);
   endproperty
   a_low_write: assert property (p_low_write) else $error("lower enables not written");

   property p_latch_hides;
      reg_wr && divisor_latch_select |=> mask_reg == $past(mask_reg);
   endproperty
   a_latch_hides: assert property (p_latch_hides) else $error("write leaked past latch select");

   property p_read_back;
      reg_rd && mask_hit |=> reg_rdata == $past(mask_reg);
   endproperty
   a_read_back: assert property (p_read_back) else $error("mask read back wrong");

   // write and read paths seen from the outside
   property p_high_write;
      reg_wr && mask_hit && enhanced_function_gate |=> mask_reg[7:4] == $past(reg_wdata[7:4]);
   endproperty
   a_high_write: assert property (p_high_write) else $error("upper not written");

   property p_mirror;
      1'b1 |=> uart_interrupt_mask == $past(mask_reg);
   endproperty
   a_mirror: assert property (p_mirror) else $error("mask copy out of step");

   property p_rdata_idle;
      !(reg_rd && mask_hit) |=> reg_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");

   property p_latch_rd;
      reg_rd && divisor_latch_select |=> reg_rdata == 8'h00;
   endproperty
   a_latch_rd: assert property (p_latch_rd) else $error("hidden mask read");

   // raw status passes through whatever the mask says
   property p_pend;
      1'b1 |=> pending_status == $past(src_status);
   endproperty
   a_pend: assert property (p_pend) else $error("status copy wrong");

   // one source alone with its enable clear must leave the line quiet
   for (genvar i = 0; i < 6; i++) begin : g_lone
      property p_lone_masked;
         src_status == uimsc_src_t'(6'h01 << i) && !enable_vec[i] |=> !irq;
      endproperty
      a_lone_masked: assert property (p_lone_masked) else $error("masked irq");
   end

   // sleep needs bit and gate, and stays off while anything is busy
   property p_gate_sleep;
      !enhanced_function_gate |=> !sleeping;
   endproperty
   a_gate_sleep: assert property (p_gate_sleep) else $error("slept, gate closed");

   property p_bit_sleep;
      !mask_reg[`UIMSC_BIT_SLEEP] |=> !sleeping;
   endproperty
   a_bit_sleep: assert property (p_bit_sleep) else $error("slept, bit clear");

   property p_irq_blocks;
      !sleeping && (|(src_status & enable_vec)) |=> !sleeping;
   endproperty
   a_irq_blocks: assert property (p_irq_blocks) else $error("slept while pending");

   property p_fifo_blocks;
      !sleeping && !(tx_fifo_empty && rx_fifo_empty) |=> !sleeping;
   endproperty
   a_fifo_blocks: assert property (p_fifo_blocks) else $error("slept with data");

   // a transmit write or a modem edge ends sleep and restarts the oscillator
   property p_tx_wake;
      sleeping && tx_write |=> !sleeping && osc_run;
   endproperty
   a_tx_wake: assert property (p_tx_wake) else $error("tx write did not wake");

   property p_modem_wake;
      sleeping && !$stable(modem_in) |=> !sleeping && osc_run;
   endproperty
   a_modem_wake: assert property (p_modem_wake) else $error("modem edge did not wake");

   c_gate_write: cover property (reg_wr && mask_hit && enhanced_function_gate);
   c_irq_raise: cover property (!irq ##1 irq);
   c_sleep: cover property (sleeping);
endmodule
`default_nettype wire

/* uimsc_top_tb_top.sv */
// testbench for the interrupt mask and sleep block
`timescale 1ns/10ps
`default_nettype none
module uimsc_top_tb_top;
   import uimsc_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [2:0] reg_addr;
   logic reg_wr, reg_rd, dls, gate, irq, sleeping, osc_run;
   logic [7:0] reg_wdata, reg_rdata, mask_q;
   logic [7:0] m = 8'h00;
   uimsc_src_t src = '0;
   uimsc_src_t pend;
   logic [3:0] modem = 4'h0;
   logic rx_in = 1'b1;
   logic txe = 1'b1;
   logic rxe = 1'b1;
   logic tx_write = 1'b0;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   uimsc_top uimsc_top_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .divisor_latch_select(dls), .enhanced_function_gate(gate),
      .src_status(src), .modem_in(modem), .rx_in(rx_in), .tx_fifo_empty(txe),
      .rx_fifo_empty(rxe), .tx_write(tx_write), .reg_rdata(reg_rdata),
      .uart_interrupt_mask(mask_q), .pending_status(pend), .irq(irq),
      .sleeping(sleeping), .osc_run(osc_run));
   uimsc_host uimsc_host_inst (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .divisor_latch_select(dls),
      .enhanced_function_gate(gate));
   initial begin
      forever #10 clock = ~clock;
   end
   task automatic end_sim();
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t byte got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t flag got %b exp %b", $time, g, e);
      end
   endtask
   // enables in source order, bits 4 and 0 carry no source
   function automatic logic [5:0] en_of(input logic [7:0] v);
      return {v[7], v[6], v[5], v[3], v[2], v[1]};
   endfunction
   // model: upper nibble refused while the gate is closed
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      uimsc_host_inst.acc(1'b1, a, d);
      if (a == 3'h1 && !dls) m = gate ? d : {m[7:4], d[3:0]};
   endtask
   task automatic rd_chk();
      logic [7:0] exp_q[$];
      exp_q.push_back(dls ? 8'h00 : m);
      uimsc_host_inst.acc(1'b0, 3'h1, 8'h00);
      #1 chk_reg(reg_rdata, exp_q.pop_front());
      @(posedge clock);
      #1 chk_reg(reg_rdata, 8'h00);
      @(posedge clock);
   endtask
   task automatic look();
      @(posedge clock);
      #1 chk_reg(mask_q, m);
      chk_reg({2'b00, pend}, {2'b00, src});
      chk_bit(irq, |(en_of(m) & src));
      @(posedge clock);
   endtask
   // raise or drop one sleep-relevant condition
   task automatic poke(input int k, input logic v);
      case (k)
         0: rx_in <= !v;
         1: txe <= !v;
         2: rxe <= !v;
         3: uimsc_host_inst.set_ctl(1'b0, !v);
         4: src <= uimsc_src_t'({5'h00, v});
         5: tx_write <= v;
         default: modem <= modem ^ {3'h0, v};
      endcase
   endtask
   initial begin
      void'($urandom(32'h96a2));
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      #1 chk_reg(mask_q, 8'h00);
      chk_reg(reg_rdata, 8'h00);
      chk_reg({2'b00, pend}, 8'h00);
      chk_bit(irq, 1'b0);
      chk_bit(sleeping, 1'b0);
      chk_bit(osc_run, 1'b1);
      @(posedge clock);
      #1 chk_bit(osc_run, 1'b1);
      chk_reg(mask_q, 8'h00);
      @(posedge clock);
      // lone masked source while the enable is still clear
      src <= uimsc_src_t'(6'h20);
      wr(3'h1, 8'hff);
      look();
      uimsc_host_inst.set_ctl(1'b0, 1'b1);
      @(posedge clock);
      for (int i = 0; i < 24; i++) begin
         src <= (i < 8) ? uimsc_src_t'(6'h3f) : uimsc_src_t'(6'($urandom));
         wr(3'h1, (i < 8) ? 8'h01 << i : 8'($urandom));
         look();
         rd_chk();
      end
      uimsc_host_inst.set_ctl(1'b1, 1'b1);
      @(posedge clock);
      wr(3'h1, 8'haa);
      rd_chk();
      uimsc_host_inst.set_ctl(1'b0, 1'b1);
      @(posedge clock);
      wr(3'h2, 8'h55);
      look();
      src <= uimsc_src_t'(6'h00);
      wr(3'h1, 8'h12);
      // each pass: asleep, then a wake or a blocker
      for (int k = 0; k < 7; k++) begin
         repeat (4) @(posedge clock);
         #1 chk_bit(sleeping, 1'b1);
         chk_bit(osc_run, 1'b0);
         @(posedge clock);
         poke(k, 1'b1);
         @(posedge clock);
         tx_write <= (k < 5);
         #1 if (k == 0 || k == 3 || k > 4) chk_bit(osc_run, 1'b1);
         @(posedge clock);
         tx_write <= 1'b0;
         repeat (4) @(posedge clock);
         #1 chk_bit(sleeping, k > 4);
         @(posedge clock);
         poke(k, 1'b0);
      end
      end_sim();
   end
endmodule
`default_nettype wire
